// file: verilog/bpx_core.sv
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
module bpx_core (
    input  wire logic       CLK_I,
    input  wire logic       RST_N_I,
    input  wire logic [7:0] ADDR_I,
    input  wire logic [7:0] WDATA_I,
    input  wire logic       WR_I,
    input  wire logic       RD_I,
    output logic      [7:0] RDATA_O,
    input  wire logic [7:0] XDATA_I,
    output logic      [7:0] XDATA_O,
    output logic            XDATA_OE_O,
    output logic      [7:0] XADDR_LO_O,
    output logic      [7:0] XADDR_HI_O,
    output logic            XADDR_HI_EN_O,
    output logic            XRD_N_O,
    output logic            XWR_N_O,
    output logic            PROG_STORE_EN_N_O,
    input  wire logic [7:0] P1_I,
    output logic      [7:0] P1_O,
    output logic            BUSY_O
);
    // Offset sign extension, used once, and instruction length, used three times
    function automatic logic [15:0] sext(input logic [7:0] v);
        return {{8{v[7]}}, v};
    endfunction
    function automatic logic [6:0] op_len(input bpx_pkg::bpx_op_t o);
        case (o)
            bpx_pkg::OP_MOV_CB, bpx_pkg::OP_CLR_C, bpx_pkg::OP_CLR_B,
            bpx_pkg::OP_SET_C, bpx_pkg::OP_SET_B, bpx_pkg::OP_CPL_C,
            bpx_pkg::OP_CPL_B: op_len = bpx_pkg::MCYC;
            default:           op_len = 7'(2 * bpx_pkg::MCYC_CLKS);
        endcase
    endfunction

    bpx_pkg::bpx_state_t st_q;
    bpx_pkg::bpx_op_t    op_q;
    bpx_pkg::bpx_xbus_t  xb_q, xb_d;
    logic [6:0]  cnt_q;
    logic [7:0]  arg1_q, arg2_q, acc_q, psw_q, dpl_q, dph_q;
    logic [7:0]  ptr0_q, ptr1_q, pcl_q, pch_q, p1_q, p2_q;
    logic [7:0]  rdata_q, xin_q, bram_q [16];
    logic [7:0]  xs1_q, xs2_q, ps1_q, ps2_q;
    logic        taken_q;

    // Two-flop synchronisers for pins
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            xs1_q <= bpx_pkg::RST_BYTE;
            xs2_q <= bpx_pkg::RST_BYTE;
            ps1_q <= bpx_pkg::RST_BYTE;
            ps2_q <= bpx_pkg::RST_BYTE;
        end else begin
            xs1_q <= XDATA_I;
            xs2_q <= xs1_q;
            ps1_q <= P1_I;
            ps2_q <= ps1_q;
        end
    end

    // Sequencing
    wire        busy     = (st_q == bpx_pkg::ST_EXEC);
    wire        last     = busy && (cnt_q == op_len(op_q) - 7'd1);
    wire        start    = WR_I && (ADDR_I == bpx_pkg::R_CMD) && !busy;
    wire        sw_wr    = WR_I && !busy;
    wire        strb_win = busy && (cnt_q >= bpx_pkg::MCYC)
                           && (cnt_q < op_len(op_q) - 7'd1);
    wire        smp      = busy && (cnt_q == op_len(op_q) - 7'd2);

    // Operation classes
    wire is_xrd = (op_q == bpx_pkg::OP_XRD_RI) || (op_q == bpx_pkg::OP_XRD_DP);
    wire is_xwr = (op_q == bpx_pkg::OP_XWR_RI) || (op_q == bpx_pkg::OP_XWR_DP);
    wire is_dp  = (op_q == bpx_pkg::OP_XRD_DP) || (op_q == bpx_pkg::OP_XWR_DP);
    wire is_tbl = (op_q == bpx_pkg::OP_TBL_DP) || (op_q == bpx_pkg::OP_TBL_PC);

    // External addresses
    wire [7:0]  ri      = arg1_q[0] ? ptr1_q : ptr0_q;
    wire [15:0] data_pointer_16    = {dph_q, dpl_q};
    wire [15:0] pc      = {pch_q, pcl_q};
    wire [15:0] tbl_a   = (op_q == bpx_pkg::OP_TBL_PC)
                          ? pc + {8'h00, acc_q}
                          : data_pointer_16 + {8'h00, acc_q};
    wire [15:0] x_a     = is_tbl ? tbl_a : (is_dp ? data_pointer_16 : {p2_q, ri});

    // Bit read path
    wire        in_sfr  = arg1_q[bpx_pkg::BIT_SPACE];
    wire [4:0]  sfr_sel = arg1_q[7:3];
    wire [2:0]  bpos    = arg1_q[2:0];
    wire [7:0]  sfr_b   = (sfr_sel == bpx_pkg::SFR_PSW) ? psw_q :
                          (sfr_sel == bpx_pkg::SFR_ACC) ? acc_q :
                          (sfr_sel == bpx_pkg::SFR_P1)  ? ps2_q :
                          (sfr_sel == bpx_pkg::SFR_P2)  ? p2_q  :
                          bpx_pkg::RST_BYTE;
    wire [7:0]  cur_b   = in_sfr ? sfr_b : bram_q[arg1_q[6:3]];
    wire        bit_v   = cur_b[bpos];
    wire        cy      = psw_q[bpx_pkg::PSW_CY];

    // Bit results; no exclusive-OR form is decoded
    wire cy_we = (op_q == bpx_pkg::OP_ANL_B) || (op_q == bpx_pkg::OP_ANL_NB)
              || (op_q == bpx_pkg::OP_ORL_B) || (op_q == bpx_pkg::OP_ORL_NB)
              || (op_q == bpx_pkg::OP_MOV_CB) || (op_q == bpx_pkg::OP_CLR_C)
              || (op_q == bpx_pkg::OP_SET_C) || (op_q == bpx_pkg::OP_CPL_C);
    wire cy_nv = (op_q == bpx_pkg::OP_ANL_B)  ? (cy & bit_v)  :
                 (op_q == bpx_pkg::OP_ANL_NB) ? (cy & ~bit_v) :
                 (op_q == bpx_pkg::OP_ORL_B)  ? (cy | bit_v)  :
                 (op_q == bpx_pkg::OP_ORL_NB) ? (cy | ~bit_v) :
                 (op_q == bpx_pkg::OP_MOV_CB) ? bit_v         :
                 (op_q == bpx_pkg::OP_SET_C)  ? 1'b1          :
                 (op_q == bpx_pkg::OP_CPL_C)  ? ~cy           : 1'b0;
    wire b_we  = (op_q == bpx_pkg::OP_MOV_BC) || (op_q == bpx_pkg::OP_CLR_B)
              || (op_q == bpx_pkg::OP_SET_B) || (op_q == bpx_pkg::OP_CPL_B)
              || ((op_q == bpx_pkg::OP_JBC) && bit_v);
    wire b_nv  = (op_q == bpx_pkg::OP_MOV_BC) ? cy     :
                 (op_q == bpx_pkg::OP_SET_B)  ? 1'b1   :
                 (op_q == bpx_pkg::OP_CPL_B)  ? ~bit_v : 1'b0;
    wire [7:0] new_b = (cur_b & ~(8'h01 << bpos)) | ({7'h00, b_nv} << bpos);

    // Branch decision; offset is second argument for bit tests
    wire take = ((op_q == bpx_pkg::OP_JC)  &&  cy)
             || ((op_q == bpx_pkg::OP_JNC) && !cy)
             || (((op_q == bpx_pkg::OP_JB) || (op_q == bpx_pkg::OP_JBC)) && bit_v)
             || ((op_q == bpx_pkg::OP_JNB) && !bit_v);
    wire [7:0]  rel    = ((op_q == bpx_pkg::OP_JC) || (op_q == bpx_pkg::OP_JNC))
                         ? arg1_q : arg2_q;
    wire [15:0] pc_tgt = pc + sext(rel);

    // Next pin state, registered below
    always_comb begin
        xb_d         = xb_q;
        xb_d.rd_n    = !(is_xrd && strb_win);
        xb_d.wr_n    = !(is_xwr && strb_win);
        xb_d.program_store_enable_n  = !(is_tbl && strb_win);
        xb_d.doe     = is_xwr && strb_win;
        xb_d.dout    = acc_q;
        xb_d.hi_drv  = busy && !last && (is_dp || is_tbl);
        xb_d.addr_lo = (busy && !last) ? x_a[7:0] : xb_q.addr_lo;
        xb_d.addr_hi = xb_d.hi_drv ? x_a[15:8] : p2_q;
    end

    // Register read decode
    wire [7:0] rd_mux =
        (ADDR_I == bpx_pkg::R_CMD)  ? {3'h0, op_q} :
        (ADDR_I == bpx_pkg::R_ARG1) ? arg1_q :
        (ADDR_I == bpx_pkg::R_ARG2) ? arg2_q :
        (ADDR_I == bpx_pkg::R_ACC)  ? acc_q  :
        (ADDR_I == bpx_pkg::R_PSW)  ? psw_q  :
        (ADDR_I == bpx_pkg::R_DPL)  ? dpl_q  :
        (ADDR_I == bpx_pkg::R_DPH)  ? dph_q  :
        (ADDR_I == bpx_pkg::R_PTR0) ? ptr0_q :
        (ADDR_I == bpx_pkg::R_PTR1) ? ptr1_q :
        (ADDR_I == bpx_pkg::R_PCL)  ? pcl_q  :
        (ADDR_I == bpx_pkg::R_PCH)  ? pch_q  :
        (ADDR_I == bpx_pkg::R_STAT) ? {6'h00, taken_q, busy} :
        (ADDR_I == bpx_pkg::R_P1)   ? p1_q   :
        (ADDR_I == bpx_pkg::R_P2)   ? p2_q   :
        (ADDR_I[7:4] == bpx_pkg::BRAM_PG) ? bram_q[ADDR_I[3:0]] :
        bpx_pkg::RST_BYTE;

    // Sequencer and read port
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            st_q    <= bpx_pkg::ST_IDLE;
            op_q    <= bpx_pkg::OP_NOP;
            cnt_q   <= '0;
            rdata_q <= bpx_pkg::RST_BYTE;
            xin_q   <= bpx_pkg::RST_BYTE;
        end else begin
            rdata_q <= RD_I ? rd_mux : bpx_pkg::RST_BYTE;
            if (smp) begin
                xin_q <= xs2_q;
            end
            case (st_q)
                bpx_pkg::ST_IDLE: begin
                    cnt_q <= '0;
                    if (start) begin
                        op_q <= bpx_pkg::bpx_op_t'(WDATA_I[4:0]);
                        st_q <= bpx_pkg::ST_EXEC;
                    end
                end
                bpx_pkg::ST_EXEC: begin
                    cnt_q <= cnt_q + 7'd1;
                    if (last) begin
                        st_q <= bpx_pkg::ST_IDLE;
                    end
                end
                default: st_q <= bpx_pkg::ST_IDLE;
            endcase
        end
    end

    // Pin outputs
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            xb_q <= '{addr_lo: bpx_pkg::RST_BYTE, addr_hi: bpx_pkg::RST_PORT, hi_drv: 1'b0,
                      rd_n: 1'b1, wr_n: 1'b1, program_store_enable_n: 1'b1, dout: bpx_pkg::RST_BYTE,
                      doe: 1'b0};
        end else begin
            xb_q <= xb_d;
        end
    end

    // Architectural state: software writes when idle, results on last cycle
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            arg1_q  <= bpx_pkg::RST_BYTE;
            arg2_q  <= bpx_pkg::RST_BYTE;
            acc_q   <= bpx_pkg::RST_BYTE;
            psw_q   <= bpx_pkg::RST_BYTE;
            dpl_q   <= bpx_pkg::RST_BYTE;
            dph_q   <= bpx_pkg::RST_BYTE;
            ptr0_q  <= bpx_pkg::RST_BYTE;
            ptr1_q  <= bpx_pkg::RST_BYTE;
            pcl_q   <= bpx_pkg::RST_BYTE;
            pch_q   <= bpx_pkg::RST_BYTE;
            p1_q    <= bpx_pkg::RST_PORT;
            p2_q    <= bpx_pkg::RST_PORT;
            taken_q <= 1'b0;
            for (int i = 0; i < 16; i++) begin
                bram_q[i] <= bpx_pkg::RST_BYTE;
            end
        end else if (sw_wr) begin
            case (ADDR_I)
                bpx_pkg::R_ARG1: arg1_q <= WDATA_I;
                bpx_pkg::R_ARG2: arg2_q <= WDATA_I;
                bpx_pkg::R_ACC:  acc_q  <= WDATA_I;
                bpx_pkg::R_PSW:  psw_q  <= WDATA_I;
                bpx_pkg::R_DPL:  dpl_q  <= WDATA_I;
                bpx_pkg::R_DPH:  dph_q  <= WDATA_I;
                bpx_pkg::R_PTR0: ptr0_q <= WDATA_I;
                bpx_pkg::R_PTR1: ptr1_q <= WDATA_I;
                bpx_pkg::R_PCL:  pcl_q  <= WDATA_I;
                bpx_pkg::R_PCH:  pch_q  <= WDATA_I;
                bpx_pkg::R_P1:   p1_q   <= WDATA_I;
                bpx_pkg::R_P2:   p2_q   <= WDATA_I;
                bpx_pkg::R_CMD:  taken_q <= 1'b0;
                default: begin
                    if (ADDR_I[7:4] == bpx_pkg::BRAM_PG) begin
                        bram_q[ADDR_I[3:0]] <= WDATA_I;
                    end
                end
            endcase
        end else if (last) begin
            if (is_xrd || is_tbl) begin
                acc_q <= xin_q;
            end
            if (cy_we) begin
                psw_q[bpx_pkg::PSW_CY] <= cy_nv;
            end
            // Bit write last so a carry-addressed bit op wins
            if (b_we && !in_sfr) begin
                bram_q[arg1_q[6:3]] <= new_b;
            end else if (b_we) begin
                case (sfr_sel)
                    bpx_pkg::SFR_PSW: psw_q <= new_b;
                    bpx_pkg::SFR_ACC: acc_q <= new_b;
                    bpx_pkg::SFR_P1:  p1_q  <= (p1_q & ~(8'h01 << bpos))
                                               | (new_b & (8'h01 << bpos));
                    bpx_pkg::SFR_P2:  p2_q  <= new_b;
                    default: ;
                endcase
            end
            taken_q <= take;
            if (take) begin
                {pch_q, pcl_q} <= pc_tgt;
            end
        end
    end

    // Output assignments, all from flops
    assign RDATA_O           = rdata_q;
    assign XDATA_O           = xb_q.dout;
    assign XDATA_OE_O        = xb_q.doe;
    assign XADDR_LO_O        = xb_q.addr_lo;
    assign XADDR_HI_O        = xb_q.addr_hi;
    assign XADDR_HI_EN_O     = xb_q.hi_drv;
    assign XRD_N_O           = xb_q.rd_n;
    assign XWR_N_O           = xb_q.wr_n;
    assign PROG_STORE_EN_N_O = xb_q.program_store_enable_n;
    assign P1_O              = p1_q;
    assign BUSY_O            = (st_q == bpx_pkg::ST_EXEC);
endmodule

// file: inc/bpx_pkg.sv
package bpx_pkg;
    // Core clock and machine cycle
    localparam int CLK_MHZ    = 25;
    localparam int MCYC_NS    = 1000;
    localparam int MCYC_CLKS  = (MCYC_NS * CLK_MHZ) / 1000;
    localparam int CNT_W      = 7;
    localparam logic [6:0] MCYC = 7'(MCYC_CLKS);

    // Register offsets on the plain port
    localparam logic [7:0] R_CMD   = 8'h00;
    localparam logic [7:0] R_ARG1  = 8'h01;
    localparam logic [7:0] R_ARG2  = 8'h02;
    localparam logic [7:0] R_ACC   = 8'h03;
    localparam logic [7:0] R_PSW   = 8'h04;
    localparam logic [7:0] R_DPL   = 8'h05;
    localparam logic [7:0] R_DPH   = 8'h06;
    localparam logic [7:0] R_PTR0  = 8'h07;
    localparam logic [7:0] R_PTR1  = 8'h08;
    localparam logic [7:0] R_PCL   = 8'h09;
    localparam logic [7:0] R_PCH   = 8'h0a;
    localparam logic [7:0] R_STAT  = 8'h0b;
    localparam logic [7:0] R_P1    = 8'h0c;
    localparam logic [7:0] R_P2    = 8'h0d;
    localparam logic [7:0] R_BRAM  = 8'h20;
    localparam logic [3:0] BRAM_PG = 4'h2;

    // Bit address space
    localparam int         BIT_SPACE = 7;
    localparam int         PSW_CY    = 7;
    localparam logic [4:0] SFR_P1    = 5'h12;
    localparam logic [4:0] SFR_P2    = 5'h14;
    localparam logic [4:0] SFR_PSW   = 5'h1a;
    localparam logic [4:0] SFR_ACC   = 5'h1c;

    // Reset values
    localparam logic [7:0] RST_BYTE  = 8'h00;
    localparam logic [7:0] RST_PORT  = 8'hff;

    // Status bits
    localparam int ST_BUSY  = 0;
    localparam int ST_TAKEN = 1;

    typedef enum logic [4:0] {
        OP_NOP    = 5'h00,
        OP_XRD_RI = 5'h01,
        OP_XWR_RI = 5'h02,
        OP_XRD_DP = 5'h03,
        OP_XWR_DP = 5'h04,
        OP_TBL_DP = 5'h05,
        OP_TBL_PC = 5'h06,
        OP_ANL_B  = 5'h07,
        OP_ANL_NB = 5'h08,
        OP_ORL_B  = 5'h09,
        OP_ORL_NB = 5'h0a,
        OP_MOV_CB = 5'h0b,
        OP_MOV_BC = 5'h0c,
        OP_CLR_C  = 5'h0d,
        OP_CLR_B  = 5'h0e,
        OP_SET_C  = 5'h0f,
        OP_SET_B  = 5'h10,
        OP_CPL_C  = 5'h11,
        OP_CPL_B  = 5'h12,
        OP_JC     = 5'h13,
        OP_JNC    = 5'h14,
        OP_JB     = 5'h15,
        OP_JNB    = 5'h16,
        OP_JBC    = 5'h17
    } bpx_op_t;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_EXEC = 1'b1
    } bpx_state_t;

    // External memory pins, all registered
    typedef struct packed {
        logic [7:0] addr_lo;
        logic [7:0] addr_hi;
        logic       hi_drv;
        logic       rd_n;
        logic       wr_n;
        logic       program_store_enable_n;
        logic [7:0] dout;
        logic       doe;
    } bpx_xbus_t;
endpackage

// file: tb/bpx_properties.sv
module bpx_properties (
    input wire logic       CLK_I,
    input wire logic       RST_N_I,
    input wire logic [7:0] ADDR_I,
    input wire logic       WR_I,
    input wire logic [7:0] XDATA_O,
    input wire logic       XDATA_OE_O,
    input wire logic [7:0] XADDR_LO_O,
    input wire logic [7:0] XADDR_HI_O,
    input wire logic       XADDR_HI_EN_O,
    input wire logic       XRD_N_O,
    input wire logic       XWR_N_O,
    input wire logic       PROG_STORE_EN_N_O,
    input wire logic       BUSY_O
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [6:0] run_q;

    // Length of the busy run, judged on the edge where busy drops
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            run_q <= 7'h00;
        end else begin
            run_q <= BUSY_O ? run_q + 7'h01 : 7'h00;
        end
    end

    default clocking dcb @(posedge CLK_I);
    endclocking
    default disable iff (!RST_N_I);

    // Strobes lag the busy flag by one register, so allow one cycle of slack
    AST_STROBE_IDLE: assert property (!BUSY_O && !$past(BUSY_O) |->
        XRD_N_O && XWR_N_O && PROG_STORE_EN_N_O) else $error("strobe outside instruction");
    AST_ONE_STROBE: assert property (int'(!XRD_N_O) + int'(!XWR_N_O)
        + int'(!PROG_STORE_EN_N_O) <= 1) else $error("two strobes at once");
    AST_WR_DRIVES: assert property (!XWR_N_O |-> XDATA_OE_O)
        else $error("write strobe without data drive");
    AST_RD_NO_DRIVE: assert property (!XRD_N_O || !PROG_STORE_EN_N_O |->
        !XDATA_OE_O) else $error("data driven during a read");
    AST_WR_HOLD: assert property (!XWR_N_O && !$past(XWR_N_O) |->
        $stable(XDATA_O) && $stable(XADDR_LO_O)) else $error("write data moved");
    AST_RD_ADDR_HOLD: assert property (!XRD_N_O && !$past(XRD_N_O) |->
        $stable({XADDR_HI_EN_O, XADDR_HI_O, XADDR_LO_O})) else $error("read address moved");
    AST_TBL_HIGH: assert property (!PROG_STORE_EN_N_O |-> XADDR_HI_EN_O)
        else $error("table read without high address");
    AST_BUSY_LEN: assert property ($fell(BUSY_O) |->
        run_q == 7'h19 || run_q == 7'h32) else $error("instruction length wrong");
    AST_BUSY_START: assert property (WR_I && ADDR_I == bpx_pkg::R_CMD && !BUSY_O |=>
        BUSY_O ##24 BUSY_O) else $error("instruction did not start");
endmodule

// file: tb/bpx_xmem.sv
module bpx_xmem (
    input  wire logic       clk_i,
    input  wire logic [1:0] lag_i,
    input  wire logic [7:0] addr_lo_i,
    input  wire logic [7:0] addr_hi_i,
    input  wire logic       rd_n_i,
    input  wire logic       wr_n_i,
    input  wire logic       program_store_enable_n_i,
    input  wire logic [7:0] data_i,
    output logic      [7:0] data_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0]  ram [0:65535];
    logic [7:0]  last_q = 8'h00;
    logic [1:0]  wait_q = 2'h0;
    logic [15:0] adr;
    logic        sel;

    assign adr = {addr_hi_i, addr_lo_i};
    assign sel = !rd_n_i || !program_store_enable_n_i;

    // Unanswered or released bus toggles so a late sample never looks right
    always_comb begin
        if (sel && wait_q >= lag_i) begin
            data_o = !rd_n_i ? ram[adr] : (adr[7:0] ^ adr[15:8] ^ 8'h3c);
        end else begin
            data_o = ~last_q;
        end
    end

    // Slow answers count strobe cycles; RAM takes the driven byte
    always_ff @(posedge clk_i) begin
        last_q <= data_o;
        wait_q <= !sel ? 2'h0 : (wait_q == 2'h3 ? wait_q : wait_q + 2'h1);
        if (!wr_n_i) begin
            ram[adr] <= data_i;
        end
    end
endmodule

// file: tb/tb_top.sv
`define CHK(nm, e, g) \
    begin \
        num_checks++; \
        if ((g) !== (e)) begin \
            mismatches++; \
            $display("mismatch %s expected %h seen %h", nm, e, g); \
        end \
    end

module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic [1:0] lag = 2'h0;
    logic [7:0] rdata, xdi, xdo, xlo, xhi, p1_o;
    logic       xoe, xhen, xrd_n, xwr_n, program_store_enable_n, busy;
    int         mismatches = 0;
    int         num_checks = 0;
    int         cyc = 0;
    logic       hen_seen = 1'b0;

    bpx_core u_bpx_core (.CLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .XDATA_I(xdi), .XDATA_O(xdo),
        .XDATA_OE_O(xoe), .XADDR_LO_O(xlo), .XADDR_HI_O(xhi), .XADDR_HI_EN_O(xhen),
        .XRD_N_O(xrd_n), .XWR_N_O(xwr_n), .PROG_STORE_EN_N_O(program_store_enable_n), .P1_I(8'h5a),
        .P1_O(p1_o), .BUSY_O(busy));
    bpx_xmem u_bpx_xmem (.clk_i(clk), .lag_i(lag), .addr_lo_i(xlo), .addr_hi_i(xhi),
        .rd_n_i(xrd_n), .wr_n_i(xwr_n), .program_store_enable_n_i(program_store_enable_n), .data_i(xdo), .data_o(xdi));

    // Clock and a cycle ceiling against hangs
    initial forever #20 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 10000) begin
            mismatches++;
            results();
        end
    end

    // Sticky: did port 2 carry address during any data strobe so far
    always @(posedge clk) begin
        if (!xrd_n || !xwr_n) begin
            hen_seen <= hen_seen | xhen;
        end
    end

    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Strobe lowered after its edge, plus an idle edge so tasks never collide
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] e);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        `CHK(nm, e, rdata)
        @(posedge clk);
    endtask

    // Starts one instruction and measures its busy length in cycles
    task automatic exec(input logic [7:0] op, input logic [7:0] a1, input logic [7:0] a2,
                        input int n);
        int c;
        c = 1;
        wr_reg(bpx_pkg::R_ARG1, a1);
        wr_reg(bpx_pkg::R_ARG2, a2);
        wr_reg(bpx_pkg::R_CMD, op);
        #1;
        while (busy === 1'b1 && c < 60) begin
            @(posedge clk);
            #1;
            c++;
        end
        `CHK("busy_cycles", n, c)
        @(posedge clk);
    endtask

    task automatic t_ext;
        wr_reg(bpx_pkg::R_P2, 8'h12);
        wr_reg(bpx_pkg::R_PTR1, 8'h34);
        wr_reg(bpx_pkg::R_ACC, 8'h5a);
        exec(8'h02, 8'h01, 8'h00, 50);
        `CHK("xram_8bit", 8'h5a, u_bpx_xmem.ram[16'h1234])
        `CHK("hi_free_8bit", 1'b0, hen_seen)
        wr_reg(bpx_pkg::R_DPH, 8'hab);
        wr_reg(bpx_pkg::R_DPL, 8'hcd);
        wr_reg(bpx_pkg::R_ACC, 8'ha5);
        exec(8'h04, 8'h00, 8'h00, 50);
        `CHK("xram_16bit", 8'ha5, u_bpx_xmem.ram[16'habcd])
        `CHK("hi_drive_16bit", 1'b1, hen_seen)
        lag <= 2'h2;
        exec(8'h01, 8'h01, 8'h00, 50);
        rd_chk("acc_rd8", bpx_pkg::R_ACC, 8'h5a);
        exec(8'h03, 8'h00, 8'h00, 50);
        rd_chk("acc_rd16", bpx_pkg::R_ACC, 8'ha5);
        lag <= 2'h0;
        $display("test ext done");
    endtask

    // Index carries into the high byte of the data pointer table base; the PC base case does not carry
    task automatic t_tbl;
        wr_reg(bpx_pkg::R_DPH, 8'h10);
        wr_reg(bpx_pkg::R_DPL, 8'hff);
        wr_reg(bpx_pkg::R_ACC, 8'h01);
        exec(8'h05, 8'h00, 8'h00, 50);
        rd_chk("tbl_data_pointer_16", bpx_pkg::R_ACC, 8'h2d);
        wr_reg(bpx_pkg::R_PCH, 8'h20);
        wr_reg(bpx_pkg::R_PCL, 8'hf0);
        wr_reg(bpx_pkg::R_ACC, 8'h0f);
        exec(8'h06, 8'h00, 8'h00, 50);
        rd_chk("tbl_pc", bpx_pkg::R_ACC, 8'he3);
        $display("test table done");
    endtask

    // Opcode, bit address, cycles, status word after
    task automatic t_bits;
        logic [31:0] bt [17] = '{
            32'h0f001980, 32'h07013200, 32'h0a013280, 32'h08003200, 32'h09023280,
            32'h0c033280, 32'h0d001900, 32'h0b031980, 32'h11001900, 32'h12d71980,
            32'h0ed71900, 32'h10d71980, 32'h0e001980, 32'h127f1980, 32'h0e931980,
            32'h0b911980, 32'h0b901900};
        wr_reg(bpx_pkg::R_ACC, 8'h00);
        wr_reg(bpx_pkg::R_PSW, 8'h00);
        wr_reg(bpx_pkg::R_BRAM, 8'h05);
        for (int i = 0; i < 17; i++) begin
            exec(bt[i][31:24], bt[i][23:16], 8'h00, int'(bt[i][15:8]));
            rd_chk("carry", bpx_pkg::R_PSW, bt[i][7:0]);
        end
        rd_chk("bit_ram_lo", bpx_pkg::R_BRAM, 8'h0c);
        rd_chk("bit_ram_top", 8'h2f, 8'h80);
        `CHK("port1_latch", 8'hf7, p1_o)
        $display("test bits done");
    endtask

    // Opcode, first and second argument, counter after, status after
    task automatic t_branch;
        logic [47:0] bj [8] = '{
            48'h1380000f8002, 48'h1410000f8000, 48'h15d57f0fff02, 48'h16d57f0fff00,
            48'h17d501100002, 48'h17d501100000, 48'h16d5800f8002, 48'h15d7020f8202};
        wr_reg(bpx_pkg::R_PSW, 8'ha0);
        wr_reg(bpx_pkg::R_PCH, 8'h10);
        wr_reg(bpx_pkg::R_PCL, 8'h00);
        for (int i = 0; i < 8; i++) begin
            exec(bj[i][47:40], bj[i][39:32], bj[i][31:24], 50);
            rd_chk("pc_lo", bpx_pkg::R_PCL, bj[i][15:8]);
            rd_chk("pc_hi", bpx_pkg::R_PCH, bj[i][23:16]);
            rd_chk("taken", bpx_pkg::R_STAT, bj[i][7:0]);
        end
        rd_chk("flag_cleared", bpx_pkg::R_PSW, 8'h80);
        $display("test branch done");
    endtask

    // Unused code runs as a no-op and a write during it is dropped
    task automatic t_misc;
        wr_reg(bpx_pkg::R_ACC, 8'h3c);
        wr_reg(bpx_pkg::R_CMD, 8'h18);
        wr_reg(bpx_pkg::R_ACC, 8'h77);
        repeat (50) @(posedge clk);
        rd_chk("acc_held", bpx_pkg::R_ACC, 8'h3c);
        rd_chk("psw_held", bpx_pkg::R_PSW, 8'h80);
        rd_chk("unmapped", 8'h1f, 8'h00);
        exec(8'h00, 8'h00, 8'h00, 50);
        rd_chk("nop_acc", bpx_pkg::R_ACC, 8'h3c);
        $display("test misc done");
    endtask

    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_ext();
        t_tbl();
        t_bits();
        t_branch();
        t_misc();
        results();
    end
endmodule

bind bpx_core bpx_properties u_bpx_properties (.CLK_I(CLK_I), .RST_N_I(RST_N_I),
    .ADDR_I(ADDR_I), .WR_I(WR_I), .XDATA_O(XDATA_O), .XDATA_OE_O(XDATA_OE_O),
    .XADDR_LO_O(XADDR_LO_O), .XADDR_HI_O(XADDR_HI_O), .XADDR_HI_EN_O(XADDR_HI_EN_O),
    .XRD_N_O(XRD_N_O), .XWR_N_O(XWR_N_O), .PROG_STORE_EN_N_O(PROG_STORE_EN_N_O),
    .BUSY_O(BUSY_O));
